// ---- design/ucmt_top.sv ----
// Purpose: Async serial unit with mode control, transmit and receive
// Assumes: CPU register port on clk_sys, 200 MHz
// Notes:   Power bit off holds the whole serial core in reset
// How it works
// - Power off stops prescaler, resets serial core
// - Transmit enable off resets transmit side
// - Receive enable off resets receive side
// - Power off drives output high, input high
// - Power off clears status, break bits, buffer
// - Mode bits all zero: unit stopped, pins freed
// - Frame: start, 7/8 data, parity, 1/2 stop
// - Direction bit picks MSB or LSB first
// - Invert bit inverts the output pin
// - Even parity: generate even, flag odd count
// - Odd parity: generate odd, flag even count
// - Zero parity: send zero, never check
// - No parity: no parity bit, no error
// - Buffer write while enabled starts a frame
// - Buffer copies into shift register, then shifts
// - Done pulse right after last stop bit
// - Transmitter idles until the buffer holds a word
`timescale 1ns/100ps
`default_nettype none
module ucmt_top (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic [7:0] reg_wr_data,
	input wire logic reg_rd_en,
	output logic [7:0] reg_rd_data,
	output logic tx_buf_ready,
	output logic serial_output_pin,
	output logic tx_pin_owned,
	output logic rx_pin_owned,
	input wire logic serial_input_pin,
	output logic transmit_done_irq,
	output logic receive_done_irq,
	output logic receive_error_irq
);
	import ucmt_pkg::*;

	// --------------------------------------------------
	// Registers and mode decode
	// --------------------------------------------------
	logic [7:0] mode_q;
	logic [7:0] divisor_q;
	logic [3:0] clk_sel_q;
	logic [4:0] ctl_q;
	logic brf_q;
	logic [2:0] err_q;
	logic [7:0] rx_buf_q;
	logic rx_full_q;
	logic [7:0] rd_mux;
	logic rst_int;
	logic txe;
	logic rxe;
	logic [1:0] ps;
	logic len8;
	logic two_stop;
	logic lsb_first;
	logic wr_mode;
	logic rd_err;
	logic rd_rxb;

	// Power bit drives the core's asynchronous reset
	assign rst_int = reset || !mode_q[MODE_POWER];
	assign txe = mode_q[MODE_TXE];
	assign rxe = mode_q[MODE_RXE];
	// Field decodes; codes live in the package
	assign ps = {mode_q[MODE_PS_HI], mode_q[MODE_PS_LO]};
	assign len8 = mode_q[MODE_CL];
	assign two_stop = mode_q[MODE_SL];
	assign lsb_first = ctl_q[CTL_DIR];
	assign wr_mode = reg_wr_en && (reg_addr == ADDR_MODE);
	assign rd_err = reg_rd_en && (reg_addr == ADDR_RX_ERR);
	assign rd_rxb = reg_rd_en && (reg_addr == ADDR_RX_BUF);
	// Pins belong to the unit only while it is enabled
	assign tx_pin_owned = mode_q[MODE_POWER] && txe;
	assign rx_pin_owned = mode_q[MODE_POWER] && rxe;

	// Configuration registers live outside the power reset
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			mode_q <= MODE_RST;
			divisor_q <= DIVISOR_RST;
			clk_sel_q <= CLK_SEL_RST;
			ctl_q <= CONTROL_RST[4:0];
		end else if (reg_wr_en) begin
			case (reg_addr)
				ADDR_MODE: mode_q <= reg_wr_data;
				ADDR_DIVISOR: divisor_q <= reg_wr_data;
				ADDR_CLK_SEL: clk_sel_q <= reg_wr_data[3:0];
				ADDR_CONTROL: ctl_q <= reg_wr_data[4:0];
				default: ;
			endcase
		end
	end

	// Break flag: set by its trigger, cleared by power or receive enable off
	always_ff @(posedge clk_sys or posedge rst_int) begin
		if (rst_int)
			brf_q <= 1'b0;
		else if (!rxe)
			brf_q <= 1'b0;
		else if (reg_wr_en && reg_addr == ADDR_CONTROL && reg_wr_data[CTL_BRT])
			brf_q <= 1'b1;
	end

	// --------------------------------------------------
	// Base clock prescaler
	// --------------------------------------------------
	logic [11:0] presc_q;
	logic [11:0] presc_mask;
	logic base_tick;

	// Held at zero while power is off, so no ticks come out unless clock select is 0, which ticks every cycle
	always_ff @(posedge clk_sys or posedge rst_int) begin
		if (rst_int)
			presc_q <= '0;
		else
			presc_q <= presc_q + 12'h001;
	end

	assign presc_mask = 12'((13'h0001 << clk_sel_q) - 13'h0001);
	assign base_tick = ((presc_q & presc_mask) == presc_mask);

	// --------------------------------------------------
	// Transmit buffer and transmitter
	// --------------------------------------------------
	ucmt_fifo_if #(.W(DATA_W)) tx_fifo ();
	ucmt_tx_state_t tx_state_q;
	logic [7:0] tx_shift_q;
	logic tx_par_q;
	logic tx_line_q;
	logic [2:0] tx_cnt_q;
	logic tx_stop2_q;
	logic tx_mid;
	logic tx_end;
	logic tx_load;
	logic [7:0] tx_word;
	logic [7:0] tx_next;
	logic tx_out;
	logic tx_out_next;
	logic [2:0] last_bit;

	// Writes land in the buffer only while transmit is enabled
	assign tx_fifo.push_valid = reg_wr_en && (reg_addr == ADDR_TX_BUF)
		&& txe;
	assign tx_fifo.push_data = reg_wr_data;
	assign tx_buf_ready = tx_fifo.push_ready;
	assign tx_fifo.pop_ready = txe && (tx_state_q == TX_IDLE);
	assign tx_load = tx_fifo.pop_ready && tx_fifo.pop_valid;
	// Seven-bit MSB-first words are pre-aligned to the top bit
	assign tx_word = (len8 || lsb_first) ? tx_fifo.pop_data
		: {tx_fifo.pop_data[6:0], 1'b0};
	assign last_bit = len8 ? 3'h7 : 3'h6;
	assign tx_out = lsb_first ? tx_shift_q[0] : tx_shift_q[7];
	assign tx_next = lsb_first ? {1'b0, tx_shift_q[7:1]}
		: {tx_shift_q[6:0], 1'b0};
	assign tx_out_next = lsb_first ? tx_next[0] : tx_next[7];

	ucmt_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.clk_sys(clk_sys),
		.reset(rst_int),
		.flush(!txe),
		.f(tx_fifo)
	);

	ucmt_bit_timer u_tx_timer (
		.clk_sys(clk_sys),
		.reset(rst_int),
		.restart(tx_load),
		.base_tick(base_tick),
		.divisor(divisor_q),
		.mid(tx_mid),
		.bit_end(tx_end)
	);

	// Frame sequencer; line level is the un-inverted bit on air
	always_ff @(posedge clk_sys or posedge rst_int) begin
		if (rst_int) begin
			tx_state_q <= TX_IDLE;
			tx_shift_q <= '0;
			tx_par_q <= 1'b0;
			tx_line_q <= 1'b1;
			tx_cnt_q <= '0;
			tx_stop2_q <= 1'b0;
		end else if (!txe) begin
			tx_state_q <= TX_IDLE;
			tx_line_q <= 1'b1;
			tx_cnt_q <= '0;
			tx_stop2_q <= 1'b0;
		end else begin
			case (tx_state_q)
				TX_IDLE: begin
					if (tx_load) begin
						tx_shift_q <= tx_word;
						// Parity over the word, masked to its length
						tx_par_q <= (ps == PAR_EVEN) ?
							^(tx_fifo.pop_data & {len8, 7'h7F}) :
							(ps == PAR_ODD) ?
							~^(tx_fifo.pop_data & {len8, 7'h7F}) :
							1'b0;
						tx_line_q <= 1'b0;
						tx_cnt_q <= '0;
						tx_stop2_q <= 1'b0;
						tx_state_q <= TX_START;
					end
				end
				TX_START: begin
					if (tx_end) begin
						tx_line_q <= tx_out;
						tx_state_q <= TX_DATA;
					end
				end
				TX_DATA: begin
					if (tx_end) begin
						tx_shift_q <= tx_next;
						if (tx_cnt_q == last_bit) begin
							if (ucmt_has_parity(ps)) begin
								tx_line_q <= tx_par_q;
								tx_state_q <= TX_PAR;
							end else begin
								tx_line_q <= 1'b1;
								tx_state_q <= TX_STOP;
							end
						end else begin
							tx_line_q <= tx_out_next;
							tx_cnt_q <= tx_cnt_q + 3'h1;
						end
					end
				end
				TX_PAR: begin
					if (tx_end) begin
						tx_line_q <= 1'b1;
						tx_state_q <= TX_STOP;
					end
				end
				TX_STOP: begin
					if (tx_end) begin
						if (two_stop && !tx_stop2_q)
							tx_stop2_q <= 1'b1;
						else
							tx_state_q <= TX_IDLE;
					end
				end
				default: tx_state_q <= TX_IDLE;
			endcase
		end
	end

	// Done pulse on the edge that ends the last stop bit
	always_ff @(posedge clk_sys or posedge rst_int) begin
		if (rst_int)
			transmit_done_irq <= 1'b0;
		else
			transmit_done_irq <= txe && (tx_state_q == TX_STOP) && tx_end
				&& (!two_stop || tx_stop2_q);
	end

	// Pin flop: forced high under power-off reset
	always_ff @(posedge clk_sys or posedge rst_int) begin
		if (rst_int)
			serial_output_pin <= 1'b1;
		else
			serial_output_pin <= tx_line_q ^ ctl_q[CTL_INV];
	end

	// --------------------------------------------------
	// Receiver
	// --------------------------------------------------
	ucmt_rx_state_t rx_state_q;
	logic rx_sync1_q;
	logic rx_sync2_q;
	logic rx_prev_q;
	logic [7:0] rx_shift_q;
	logic [2:0] rx_cnt_q;
	logic rx_par_q;
	logic rx_fall;
	logic rx_start;
	logic rx_mid;
	logic rx_done;
	logic [7:0] rx_word;
	logic rx_par_err;
	logic [2:0] rx_err;

	// Two-flop synchroniser; power-off reset holds the view high
	always_ff @(posedge clk_sys or posedge rst_int) begin
		if (rst_int) begin
			rx_sync1_q <= 1'b1;
			rx_sync2_q <= 1'b1;
			rx_prev_q <= 1'b1;
		end else begin
			rx_sync1_q <= serial_input_pin;
			rx_sync2_q <= rx_sync1_q;
			rx_prev_q <= rx_sync2_q;
		end
	end

	assign rx_fall = rx_prev_q && !rx_sync2_q;
	assign rx_start = rxe && (rx_state_q == RX_IDLE) && rx_fall;
	assign rx_done = rxe && (rx_state_q == RX_STOP) && rx_mid;
	// LSB-first seven-bit words sit one place too high
	assign rx_word = (lsb_first && !len8) ? {1'b0, rx_shift_q[7:1]}
		: (len8 ? rx_shift_q : {1'b0, rx_shift_q[6:0]});
	assign rx_par_err = ((ps == PAR_EVEN) && (^{rx_word, rx_par_q}))
		|| ((ps == PAR_ODD) && !(^{rx_word, rx_par_q}));
	assign rx_err[ERR_PARITY] = rx_par_err;
	assign rx_err[ERR_FRAMING] = !rx_sync2_q;
	assign rx_err[ERR_OVERRUN] = rx_full_q;

	ucmt_bit_timer u_rx_timer (
		.clk_sys(clk_sys),
		.reset(rst_int),
		.restart(rx_start),
		.base_tick(base_tick),
		.divisor(divisor_q),
		.mid(rx_mid),
		.bit_end()
	);

	// Samples at mid-bit; only one stop bit is checked
	always_ff @(posedge clk_sys or posedge rst_int) begin
		if (rst_int) begin
			rx_state_q <= RX_IDLE;
			rx_shift_q <= '0;
			rx_cnt_q <= '0;
			rx_par_q <= 1'b0;
		end else if (!rxe) begin
			rx_state_q <= RX_IDLE;
			rx_cnt_q <= '0;
		end else begin
			case (rx_state_q)
				RX_IDLE: begin
					if (rx_start)
						rx_state_q <= RX_START;
				end
				RX_START: begin
					if (rx_mid) begin
						// A glitch shorter than half a bit is dropped
						rx_state_q <= rx_sync2_q ? RX_IDLE : RX_DATA;
						rx_cnt_q <= '0;
						rx_par_q <= 1'b0;
					end
				end
				RX_DATA: begin
					if (rx_mid) begin
						rx_shift_q <= lsb_first ? {rx_sync2_q, rx_shift_q[7:1]}
							: {rx_shift_q[6:0], rx_sync2_q};
						rx_cnt_q <= rx_cnt_q + 3'h1;
						if (rx_cnt_q == last_bit)
							rx_state_q <= ucmt_has_parity(ps) ? RX_PAR
								: RX_STOP;
					end
				end
				RX_PAR: begin
					if (rx_mid) begin
						rx_par_q <= rx_sync2_q;
						rx_state_q <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (rx_mid)
						rx_state_q <= RX_IDLE;
				end
				default: rx_state_q <= RX_IDLE;
			endcase
		end
	end

	// Receive buffer; an overrun keeps the unread word
	always_ff @(posedge clk_sys or posedge rst_int) begin
		if (rst_int) begin
			rx_buf_q <= '0;
			rx_full_q <= 1'b0;
		end else if (rx_done && !rx_full_q) begin
			rx_buf_q <= rx_word;
			rx_full_q <= 1'b1;
		end else if (rd_rxb) begin
			rx_full_q <= 1'b0;
		end
	end

	// Error status clears on read; a new error wins over the read
	always_ff @(posedge clk_sys or posedge rst_int) begin
		if (rst_int)
			err_q <= '0;
		else if (rx_done)
			err_q <= (rd_err ? 3'h0 : err_q) | rx_err;
		else if (rd_err)
			err_q <= '0;
	end

	// Merge bit folds the error request into the done request
	always_ff @(posedge clk_sys or posedge rst_int) begin
		if (rst_int) begin
			receive_done_irq <= 1'b0;
			receive_error_irq <= 1'b0;
		end else begin
			receive_done_irq <= rx_done && (rx_err == 3'h0 || mode_q[MODE_ISRM]);
			receive_error_irq <= rx_done && (rx_err != 3'h0)
				&& !mode_q[MODE_ISRM];
		end
	end

	// --------------------------------------------------
	// Read port
	// --------------------------------------------------
	// Trigger bits always read back as zero
	always_comb begin
		rd_mux = 8'h00;
		case (reg_addr)
			ADDR_MODE: rd_mux = mode_q;
			ADDR_RX_ERR: rd_mux = {5'h00, err_q};
			ADDR_TX_STAT: begin
				rd_mux[STAT_BUF_FULL] = !tx_fifo.push_ready;
				rd_mux[STAT_SHIFTING] = (tx_state_q != TX_IDLE);
			end
			ADDR_RX_BUF: rd_mux = rx_buf_q;
			ADDR_CLK_SEL: rd_mux = {4'h0, clk_sel_q};
			ADDR_DIVISOR: rd_mux = divisor_q;
			ADDR_CONTROL: rd_mux = {brf_q, 2'b00, ctl_q};
			default: rd_mux = 8'h00;
		endcase
	end

	// Read data registered one edge after the strobe
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			reg_rd_data <= 8'h00;
		else if (reg_rd_en)
			reg_rd_data <= rd_mux;
	end

	// Mode write while powered keeps the rest intact
	logic unused_ok;
	assign unused_ok = wr_mode;
endmodule
`default_nettype wire

// ---- design/ucmt_pkg.sv ----
// Purpose: Shared constants and types of the async serial unit
// Assumes: 8-bit register port, one system clock
// Notes:   Field positions and codes of the mode register are gathered here
package ucmt_pkg;
	// --------------------------------------------------
	// Register addresses
	// --------------------------------------------------
	localparam logic [15:0] ADDR_MODE = 16'hFF90;
	localparam logic [15:0] ADDR_RX_ERR = 16'hFF91;
	localparam logic [15:0] ADDR_TX_STAT = 16'hFF92;
	localparam logic [15:0] ADDR_TX_BUF = 16'hFF93;
	localparam logic [15:0] ADDR_RX_BUF = 16'hFF94;
	localparam logic [15:0] ADDR_CLK_SEL = 16'hFF96;
	localparam logic [15:0] ADDR_DIVISOR = 16'hFF97;
	localparam logic [15:0] ADDR_CONTROL = 16'hFF98;
	// --------------------------------------------------
	// Reset values
	// --------------------------------------------------
	localparam logic [7:0] MODE_RST = 8'h01;
	localparam logic [7:0] CONTROL_RST = 8'h16;
	localparam logic [7:0] DIVISOR_RST = 8'hFF;
	localparam logic [3:0] CLK_SEL_RST = 4'h0;
	// --------------------------------------------------
	// Field positions
	// --------------------------------------------------
	localparam int MODE_POWER = 7;
	localparam int MODE_TXE = 6;
	localparam int MODE_RXE = 5;
	localparam int MODE_PS_HI = 4;
	localparam int MODE_PS_LO = 3;
	localparam int MODE_CL = 2;
	localparam int MODE_SL = 1;
	localparam int MODE_ISRM = 0;
	localparam int CTL_BRF = 7;
	localparam int CTL_BRT = 6;
	localparam int CTL_DIR = 1;
	localparam int CTL_INV = 0;
	localparam int ERR_PARITY = 2;
	localparam int ERR_FRAMING = 1;
	localparam int ERR_OVERRUN = 0;
	localparam int STAT_BUF_FULL = 1;
	localparam int STAT_SHIFTING = 0;
	// --------------------------------------------------
	// Parity select codes and sizes
	// --------------------------------------------------
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_ZERO = 2'h1;
	localparam logic [1:0] PAR_ODD = 2'h2;
	localparam logic [1:0] PAR_EVEN = 2'h3;
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 16;

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
		ucmt_tx_state_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
		ucmt_rx_state_t;

	// Parity bit present in the frame
	function automatic logic ucmt_has_parity(input logic [1:0] ps);
		return ps != PAR_NONE;
	endfunction
endpackage

// ---- design/ucmt_fifo_if.sv ----
// Purpose: Valid/ready carrier between the unit and its buffer
// Assumes: Single clock domain
// Notes:   One push side, one pop side
`timescale 1ns/100ps
`default_nettype none
interface ucmt_fifo_if #(parameter int W = 8);
	logic push_valid;
	logic push_ready;
	logic [W-1:0] push_data;
	logic pop_valid;
	logic pop_ready;
	logic [W-1:0] pop_data;
	modport fill(output push_valid, output push_data, input push_ready);
	modport drain(input pop_valid, input pop_data, output pop_ready);
	modport store(input push_valid, input push_data, input pop_ready,
		output push_ready, output pop_valid, output pop_data);
endinterface
`default_nettype wire

// ---- design/ucmt_fifo.sv ----
// Purpose: Transmit data buffer, first in first out
// Assumes: DEPTH is a power of two
// Notes:   Words sit in flops, so pop data comes from a register
`timescale 1ns/100ps
`default_nettype none
module ucmt_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic flush,
	ucmt_fifo_if.store f
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_q [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	logic full;
	logic empty;
	logic push;
	logic pop;

	// Extra pointer bit tells full from empty
	assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
	assign empty = (wr_q == rd_q);
	assign push = f.push_valid && !full;
	assign pop = f.pop_ready && !empty;
	assign f.push_ready = !full;
	assign f.pop_valid = !empty;
	assign f.pop_data = mem_q[rd_q[AW-1:0]];

	// Pointers; flush empties the buffer in one edge
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wr_q <= '0;
			rd_q <= '0;
		end else if (flush) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push)
				wr_q <= wr_q + (AW+1)'(1);
			if (pop)
				rd_q <= rd_q + (AW+1)'(1);
		end
	end

	// Storage has no reset; pointers guard stale words
	always_ff @(posedge clk_sys) begin
		if (push)
			mem_q[wr_q[AW-1:0]] <= f.push_data;
	end
endmodule
`default_nettype wire

// ---- design/ucmt_bit_timer.sv ----
// Purpose: Times one serial bit from base clock ticks
// Assumes: divisor is 8 or more
// Notes:   One bit lasts twice the divisor in base ticks
`timescale 1ns/100ps
`default_nettype none
module ucmt_bit_timer (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic restart,
	input wire logic base_tick,
	input wire logic [7:0] divisor,
	output logic mid,
	output logic bit_end
);
	logic [8:0] cnt_q;
	logic [8:0] last;

	assign last = {divisor, 1'b0} - 9'h001;
	// Middle pulse is where the receiver samples
	assign mid = base_tick && !restart && (cnt_q == {1'b0, divisor} - 9'h001);
	assign bit_end = base_tick && !restart && (cnt_q == last);

	// Counter restarts on a frame edge
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset)
			cnt_q <= '0;
		else if (restart)
			cnt_q <= '0;
		else if (base_tick)
			cnt_q <= (cnt_q == last) ? 9'h000 : cnt_q + 9'h001;
	end
endmodule
`default_nettype wire

// ---- tb/ucmt_asserts.sv ----
// Purpose: Port-level checks of the async serial unit
// Assumes: Control bits rewritten only while enables are off
// Notes:   Shadows mode and invert bits from register writes
`timescale 1ns/100ps
`default_nettype none
module ucmt_asserts (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic [7:0] reg_wr_data,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_rd_data,
	input wire logic serial_output_pin,
	input wire logic tx_pin_owned,
	input wire logic rx_pin_owned,
	input wire logic transmit_done_irq
);
	import ucmt_pkg::*;
	logic [7:0] mode_q;
	logic inv_q;
	logic [7:0] idle_q;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);
	// Mode shadow, same reset value as the register
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			mode_q <= MODE_RST;
		end else if (reg_wr_en && reg_addr == ADDR_MODE) begin
			mode_q <= reg_wr_data;
		end
	end
	// Invert shadow
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			inv_q <= CONTROL_RST[CTL_INV];
		end else if (reg_wr_en && reg_addr == ADDR_CONTROL) begin
			inv_q <= reg_wr_data[CTL_INV];
		end
	end
	// Idle run length; saturates so a long wait never wraps
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			idle_q <= 8'h00;
		end else if (serial_output_pin == inv_q) begin
			idle_q <= 8'h00;
		end else if (idle_q != 8'hFF) begin
			idle_q <= idle_q + 8'h01;
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_off_pin;
		!mode_q[MODE_POWER] |=> serial_output_pin;
	endproperty
	property p_tx_own;
		tx_pin_owned == (mode_q[MODE_POWER] && mode_q[MODE_TXE]);
	endproperty
	property p_rx_own;
		rx_pin_owned == (mode_q[MODE_POWER] && mode_q[MODE_RXE]);
	endproperty
	property p_start;
		reg_wr_en && reg_addr == ADDR_TX_BUF && tx_pin_owned
			&& idle_q > 8'hF9 |-> ##[1:4] serial_output_pin == inv_q;
	endproperty
	property p_irq_pulse;
		transmit_done_irq |=> !transmit_done_irq;
	endproperty
	property p_irq_lvl;
		transmit_done_irq |-> serial_output_pin != inv_q;
	endproperty
	property p_irq_own;
		(!tx_pin_owned) [*2] |-> !transmit_done_irq;
	endproperty
	property p_mode_rd;
		reg_rd_en && !reg_wr_en && reg_addr == ADDR_MODE
			|=> reg_rd_data == mode_q;
	endproperty
	a_off_pin: assert property (p_off_pin)
		else $error("pin not high with power off");
	a_tx_own: assert property (p_tx_own)
		else $error("tx pin ownership wrong");
	a_rx_own: assert property (p_rx_own)
		else $error("rx pin ownership wrong");
	a_start: assert property (p_start)
		else $error("no start bit after buffer write");
	a_irq_pulse: assert property (p_irq_pulse)
		else $error("done pulse too long");
	a_irq_lvl: assert property (p_irq_lvl)
		else $error("done pulse before stop level");
	a_irq_own: assert property (p_irq_own)
		else $error("done pulse while disabled");
	a_mode_rd: assert property (p_mode_rd)
		else $error("mode readback wrong");
	c_done: cover property (transmit_done_irq);
	c_off: cover property (!mode_q[MODE_POWER] && !serial_output_pin);
	c_err_rd: cover property (reg_rd_en && reg_addr == ADDR_RX_ERR);
endmodule
`default_nettype wire

// ---- tb/ucmt_remote.sv ----
// Purpose: Remote serial partner on the two line pins
// Assumes: Fixed bit time in system clocks
// Notes:   Drives its line at falling edges, idles high
`timescale 1ns/100ps
`default_nettype none
module ucmt_remote #(
	parameter int BIT_CYC = 16
) (
	input wire logic clk_sys,
	input wire logic serial_output_pin,
	output logic serial_input_pin
);
	// Line rests high between frames
	initial serial_input_pin = 1'b1;
	// Sends n frame bits, bit 0 first
	task automatic send(input logic [11:0] f, input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge clk_sys);
			serial_input_pin = f[i];
			repeat (BIT_CYC - 1) @(negedge clk_sys);
		end
		@(negedge clk_sys);
		serial_input_pin = 1'b1;
	endtask
	// Waits for a start edge, samples n bits at mid-bit
	task automatic grab(input logic inv, input int n,
		output logic [11:0] f);
		int w = 0;
		f = 12'hFFF;
		while (serial_output_pin !== inv && w < 40) begin
			@(negedge clk_sys);
			w++;
		end
		repeat (BIT_CYC / 2) @(negedge clk_sys);
		for (int i = 0; i < n; i++) begin
			f[i] = serial_output_pin ^ inv;
			// Return mid stop bit, done pulse still ahead
			if (i < n - 1)
				repeat (BIT_CYC) @(negedge clk_sys);
		end
	endtask
endmodule
`default_nettype wire

// ---- tb/tb_ucmt_top.sv ----
// Purpose: Register-driven bench of the async serial unit
// Assumes: Clock select 0 and divisor 8, so a bit is 16 cycles
// Notes:   Partner drives the input line and samples the output
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin \
	tests_run++; \
	if ((g) !== (e)) begin \
		failures++; \
		$display("Error %s expected %h seen %h", nm, e, g); \
	end \
end
module tb_ucmt_top;
	import ucmt_pkg::*;
	logic clk_sys, reset, reg_wr_en, reg_rd_en, tx_buf_ready;
	logic [15:0] reg_addr;
	logic [7:0] reg_wr_data, reg_rd_data;
	logic serial_output_pin, serial_input_pin, transmit_done_irq;
	logic tx_pin_owned, rx_pin_owned, receive_done_irq, receive_error_irq;
	int failures = 0;
	int tests_run = 0;
	int cyc = 0;
	// Frame cases: mode low bits, control low bits, data
	logic [4:0] tm [6] = '{5'h1C, 5'h1C, 5'h1C, 5'h12, 5'h04, 5'h0C};
	logic [1:0] tc [6] = '{2'h2, 2'h0, 2'h1, 2'h2, 2'h2, 2'h2};
	logic [7:0] td [6] = '{8'h55, 8'h55, 8'h55, 8'h36, 8'h87, 8'hFF};
	// Receive cases: mode low bits, parity flip, parity error
	logic [4:0] rm [5] = '{5'h1C, 5'h1C, 5'h14, 5'h0C, 5'h04};
	logic rf [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
	logic re [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
	ucmt_top u_ucmt_top (.clk_sys(clk_sys), .reset(reset),
		.reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
		.reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
		.reg_rd_data(reg_rd_data), .tx_buf_ready(tx_buf_ready),
		.serial_output_pin(serial_output_pin),
		.tx_pin_owned(tx_pin_owned), .rx_pin_owned(rx_pin_owned),
		.serial_input_pin(serial_input_pin),
		.transmit_done_irq(transmit_done_irq),
		.receive_done_irq(receive_done_irq),
		.receive_error_irq(receive_error_irq));
	ucmt_remote u_ucmt_remote (.clk_sys(clk_sys),
		.serial_output_pin(serial_output_pin),
		.serial_input_pin(serial_input_pin));
	// 200 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// Hang guard, well above the expected run
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			$display("Error timeout expected %h seen %h", 0, cyc);
			complete_run();
		end
	end
	// Receive pulses last one cycle: count them, keep the last
	logic [5:0] rx_irq_q = 6'h00;
	always @(posedge clk_sys) begin
		if (receive_done_irq || receive_error_irq)
			rx_irq_q <= {rx_irq_q[5:2] + 4'h1, receive_error_irq,
				receive_done_irq};
	end
	task automatic complete_run;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wr_data = d;
		reg_wr_en = 1'b1;
		@(negedge clk_sys);
		reg_wr_en = 1'b0;
	endtask
	// Reads one register and compares it
	task automatic rc(input logic [15:0] a, input logic [7:0] e);
		@(negedge clk_sys);
		reg_addr = a;
		reg_rd_en = 1'b1;
		@(negedge clk_sys);
		reg_rd_en = 1'b0;
		`CHK($sformatf("reg %h", a), e, reg_rd_data)
	endtask
	// Stop, configure, power, then enables, in that order
	task automatic setup(input logic [4:0] m, input logic [1:0] c);
		wr(ADDR_MODE, 8'h80);
		wr(ADDR_MODE, 8'h00);
		wr(ADDR_CONTROL, {6'h05, c});
		wr(ADDR_DIVISOR, 8'h08);
		wr(ADDR_CLK_SEL, 8'h00);
		wr(ADDR_MODE, {3'h0, m});
		wr(ADDR_MODE, {3'h4, m});
		repeat (2) @(negedge clk_sys);
		wr(ADDR_MODE, {3'h7, m});
	endtask
	// Expected logical frame, start bit at index 0
	function automatic logic [11:0] frame(input logic [4:0] m,
		input logic lsb, input logic [7:0] d, output int n);
		logic [7:0] v;
		int len;
		len = m[2] ? 8 : 7;
		v = m[2] ? d : {1'b0, d[6:0]};
		frame = 12'hFFE;
		for (int i = 0; i < len; i++)
			frame[i + 1] = lsb ? v[i] : v[len - 1 - i];
		if (m[4:3] != PAR_NONE)
			frame[len + 1] = m[4:3] == PAR_EVEN ? ^v
				: m[4:3] == PAR_ODD ? ~^v : 1'b0;
		n = len + 2 + int'(m[1]) + int'(m[4:3] != PAR_NONE);
	endfunction
	// Starts a frame, then cuts it with a mode write
	task automatic abort(input logic [7:0] m);
		wr(ADDR_MODE, 8'hFC);
		wr(ADDR_TX_BUF, 8'h00);
		repeat (40) @(negedge clk_sys);
		wr(ADDR_MODE, m);
		repeat (3) @(negedge clk_sys);
		`CHK("pin", 1'b1, serial_output_pin)
		rc(ADDR_TX_STAT, 8'h00);
	endtask
	initial begin
		logic [11:0] e, f;
		int n, w;
		reg_addr = ADDR_MODE;
		reg_wr_data = 8'h00;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reset = 1'b1;
		repeat (20) @(negedge clk_sys);
		reset = 1'b0;
		rc(ADDR_MODE, MODE_RST);
		rc(ADDR_CONTROL, CONTROL_RST);
		rc(ADDR_DIVISOR, DIVISOR_RST);
		rc(ADDR_TX_STAT, 8'h00);
		rc(16'hFF95, 8'h00);
		$display("reset values done");
		for (int i = 0; i < 6; i++) begin
			setup(tm[i], tc[i]);
			repeat (260) @(negedge clk_sys);
			e = frame(tm[i], tc[i][1], td[i], n);
			wr(ADDR_TX_BUF, td[i]);
			u_ucmt_remote.grab(tc[i][0], n, f);
			`CHK("frame", e, f)
			w = 0;
			while (transmit_done_irq !== 1'b1 && w < 30) begin
				@(negedge clk_sys);
				w++;
			end
			`CHK("done", 1'b1, transmit_done_irq)
			repeat (40) @(negedge clk_sys);
			`CHK("idle", ~tc[i][0], serial_output_pin)
			rc(ADDR_TX_STAT, 8'h00);
			`CHK("ready", 1'b1, tx_buf_ready)
			$display("transmit case %0d done", i);
		end
		for (int i = 0; i < 5; i++) begin
			setup(rm[i], 2'h2);
			e = frame(rm[i], 1'b1, 8'h55, n);
			e[9] = e[9] ^ rf[i];
			u_ucmt_remote.send(e, n);
			repeat (40) @(negedge clk_sys);
			rc(ADDR_RX_ERR, {5'h00, re[i], 2'h0});
			rc(ADDR_RX_BUF, 8'h55);
			`CHK("irq", {4'(i + 1), re[i], ~re[i]}, rx_irq_q)
			$display("receive case %0d done", i);
		end
		setup(5'h1C, 2'h2);
		e = frame(5'h1C, 1'b1, 8'h55, n);
		e[9] = ~e[9];
		u_ucmt_remote.send(e, n);
		repeat (40) @(negedge clk_sys);
		abort(8'h9C);
		abort(8'h1C);
		rc(ADDR_RX_ERR, 8'h00);
		rc(ADDR_RX_BUF, 8'h00);
		rc(ADDR_CONTROL, 8'h16);
		`CHK("owned", 2'h0, {tx_pin_owned, rx_pin_owned})
		$display("power off case done");
		complete_run();
	end
endmodule
bind ucmt_top ucmt_asserts u_ucmt_asserts (.clk_sys(clk_sys),
	.reset(reset), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
	.reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
	.reg_rd_data(reg_rd_data), .serial_output_pin(serial_output_pin),
	.tx_pin_owned(tx_pin_owned), .rx_pin_owned(rx_pin_owned),
	.transmit_done_irq(transmit_done_irq));
`default_nettype wire
